// ### hdl/mcdma_fetch.sv
// Descriptor memory sequencer: four-word fetch or one status write
`timescale 1ns/1ns
module mcdma_fetch
    import mcdma_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Job requests from the engine
    input wire logic go_rd,
    input wire logic go_wr,
    input wire logic [31:0] base,
    input wire logic [31:0] wdata,
    output logic done,
    output mcdma_desc_t desc,
    // Memory port
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic req_q, req_d; // Request outstanding
    logic we_q, we_d; // Current job writes
    logic done_q, done_d; // Job finished pulse
    logic [31:0] addr_q, addr_d; // Word address
    logic [31:0] wd_q, wd_d; // Status word to write
    logic [1:0] idx_q, idx_d; // Word being read
    mcdma_desc_t desc_q, desc_d; // Collected descriptor

    // Next values; one job at a time, requests while busy are dropped
    always_comb begin
        req_d = req_q;
        we_d = we_q;
        done_d = 1'b0;
        addr_d = addr_q;
        wd_d = wd_q;
        idx_d = idx_q;
        desc_d = desc_q;
        if (req_q && mem_ack) begin
            if (we_q) begin
                // Status write accepted
                req_d = 1'b0;
                done_d = 1'b1;
            end else begin
                unique case (idx_q)
                    2'h0: desc_d.link = {mem_rdata[31:PTR_LSB], 6'h00}; // see [RULE_17]
                    2'h1: desc_d.rd = mem_rdata;
                    2'h2: desc_d.wr = mem_rdata;
                    2'h3: desc_d.ctl = mem_rdata;
                endcase
                if (idx_q == DW_LAST) begin
                    req_d = 1'b0;
                    done_d = 1'b1;
                end else begin
                    // Reserved words between are skipped, see [RULE_15]
                    idx_d = idx_q + 2'h1;
                    addr_d = addr_q + {26'h0, DW_STEP};
                end
            end
        end else if (go_rd && !req_q) begin
            req_d = 1'b1;
            we_d = 1'b0;
            addr_d = base + {26'h0, DW_LINK};
            idx_d = 2'h0;
        end else if (go_wr && !req_q) begin
            req_d = 1'b1;
            we_d = 1'b1;
            addr_d = base + {26'h0, DW_STAT};
            wd_d = wdata;
        end
    end

    // Registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            req_q <= 1'b0;
            we_q <= 1'b0;
            done_q <= 1'b0;
            addr_q <= RST_WORD;
            wd_q <= RST_WORD;
            idx_q <= 2'h0;
            desc_q <= '0;
        end else begin
            req_q <= req_d;
            we_q <= we_d;
            done_q <= done_d;
            addr_q <= addr_d;
            wd_q <= wd_d;
            idx_q <= idx_d;
            desc_q <= desc_d;
        end
    end

    assign done = done_q;
    assign desc = desc_q;
    assign mem_req = req_q;
    assign mem_we = we_q;
    assign mem_addr = addr_q;
    assign mem_wdata = wd_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_desc_align: assert property ( // see [RULE_17]
        @(posedge mclk) disable iff (srst)
        $rose(req_q) && !we_q |-> addr_q[5:0] == 6'h00)
    else $error("descriptor fetch not on a 64-byte step");

    chk_word_stride: assert property ( // see [RULE_15]
        @(posedge mclk) disable iff (srst)
        req_q && mem_ack && !we_q && idx_q != DW_LAST
        |=> req_q && addr_q == $past(addr_q) + 32'h8)
    else $error("descriptor word stride wrong");

endmodule // mcdma_fetch

// ### hdl/mcdma_pkg.sv
// Shared constants and types of the memory copy engine setup block
package mcdma_pkg;

    // ----------------------------------------
    // Register offsets in the memory window
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00; // Engine control
    localparam logic [7:0] OFS_STAT = 8'h04; // Engine status
    localparam logic [7:0] OFS_CUR = 8'h08; // Current descriptor pointer
    localparam logic [7:0] OFS_TAIL = 8'h10; // Tail descriptor pointer
    localparam logic [7:0] OFS_SRC = 8'h18; // Simple-mode read start
    localparam logic [7:0] OFS_DST = 8'h20; // Simple-mode write start
    localparam logic [7:0] OFS_LEN = 8'h28; // Length, write launches

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int CTL_CHAIN_BIT = 0; // Chained mode select
    localparam int STA_IDLE_BIT = 1; // Engine idle
    localparam int STA_ERR_LSB = 4; // Internal, slave, decode errors
    localparam int LEN_W = 23; // Length field width
    localparam int PTR_LSB = 6; // Descriptors sit on 64-byte steps
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [22:0] SIMPLE_MAX_LEN = 23'h7f_fffe; // 8,388,606
    localparam logic [22:0] DESC_MAX_LEN = 23'h07_ffff; // 524,287

    // ----------------------------------------
    // Descriptor word layout
    // ----------------------------------------
    localparam logic [5:0] DW_LINK = 6'h00; // Link to next descriptor
    localparam logic [5:0] DW_RD = 6'h08; // Read start
    localparam logic [5:0] DW_WR = 6'h10; // Write start
    localparam logic [5:0] DW_CTL = 6'h18; // Control, length in 22:0
    localparam logic [5:0] DW_STAT = 6'h1c; // Status written back
    localparam logic [5:0] DW_STEP = 6'h08; // Stride between used words
    localparam logic [1:0] DW_LAST = 2'h3; // Index of the control word
    localparam int DS_ERR_LSB = 28; // Internal, slave, decode at 28..30
    localparam int DS_DONE_BIT = 31; // Completed without error

    // ----------------------------------------
    // Mover error lanes and error indices
    // ----------------------------------------
    localparam int MERR_SLV = 0;
    localparam int MERR_DEC = 1;
    localparam int ERR_INT = 0;
    localparam int ERR_SLV = 1;
    localparam int ERR_DEC = 2;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] link; // Next pointer, low bits forced to zero
        logic [31:0] rd; // Read start word
        logic [31:0] wr; // Write start word
        logic [31:0] ctl; // Control word
    } mcdma_desc_t;

    typedef struct packed {
        logic [31:0] src; // First read address
        logic [31:0] dst; // First write address
        logic [22:0] len; // Byte count
    } mcdma_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SMOVE = 3'b001,
        ST_FETCH = 3'b010,
        ST_DMOVE = 3'b011,
        ST_WBACK = 3'b100
    } mcdma_state_t;

endpackage

// ### hdl/mcdma_setup.sv
// Setup side of the memory copy engine: registers, simple and chained modes
// Behaviour
// [RULE_01] Write-start register at 0x20 feeds simple copies
// [RULE_02] Host memory target: aperture base plus 19 bits
// [RULE_03] Host memory target: load bridge translation first
// [RULE_04] Write write-start register only while idle
// [RULE_05] Length bits 22:0 at 0x28, up to 8,388,606
// [RULE_06] Length write launches the simple copy
// [RULE_07] Zero length: no copy, internal error flagged
// [RULE_08] Length bits 31:23 ignore writes, read zero
// [RULE_09] Write length register only while idle
// [RULE_10] Descriptors used only with chained mode selected
// [RULE_11] Descriptor is eight words with link
// [RULE_12] One descriptor moves at most 524,287 bytes
// [RULE_13] Follow links until the last descriptor completes
// [RULE_14] Software places descriptors on 64-byte steps
// [RULE_15] Link, read, write, control, status word offsets
// [RULE_16] Next address is link bits 31:6, six zeros
// [RULE_17] Link bits 5:0 are forced to zero
// [RULE_18] Tail write in chained mode starts fetching
// [RULE_19] Descriptor error halts engine, idle after shutdown
`timescale 1ns/1ns
module mcdma_setup
    import mcdma_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic SRST,
    // Register port
    input wire logic REG_WE,
    input wire logic REG_RE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    // Data mover command and completion
    output logic MOV_VALID,
    input wire logic MOV_READY,
    output mcdma_cmd_t MOV_CMD,
    input wire logic MOV_DONE,
    input wire logic [1:0] MOV_ERR,
    // Descriptor memory port
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [31:0] MEM_ADDR,
    output logic [31:0] MEM_WDATA,
    input wire logic MEM_ACK,
    input wire logic [31:0] MEM_RDATA,
    // Engine status
    output logic ENGINE_IDLE
);

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    // Write strobe aimed at one offset
    function automatic logic hit(input logic we, input logic [7:0] a, input logic [7:0] o);
        return we && (a == o);
    endfunction

    // Length that the mover cannot take
    function automatic logic bad_len(input logic [22:0] n, input logic [22:0] mx);
        return (n == 23'h0) || (n > mx);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    mcdma_state_t st_q, st_d; // Engine sequencer
    logic chain_q, chain_d; // Chained mode select
    logic [31:0] src_q, src_d; // Simple read start
    logic [31:0] dst_q, dst_d; // Simple write start
    logic [22:0] len_q, len_d; // Simple byte count
    logic [25:0] cur_q, cur_d; // Current descriptor, 64-byte units
    logic [25:0] tail_q, tail_d; // Pause point
    logic [2:0] err_q, err_d; // Sticky engine errors
    logic [2:0] derr_q, derr_d; // Errors of the descriptor in hand
    logic mov_q, mov_d; // Command offered to the mover
    mcdma_cmd_t cmd_q, cmd_d; // Command contents
    logic [31:0] rdata_q, rdata_d; // Read data

    // Links to the memory sequencer
    logic go_rd, go_wr, f_done;
    logic [31:0] f_base, wb_word;
    mcdma_desc_t f_desc;

    // Decoded strobes
    logic wr_len, wr_tail, idle;
    assign wr_len = hit(REG_WE, REG_ADDR, OFS_LEN);
    assign wr_tail = hit(REG_WE, REG_ADDR, OFS_TAIL);
    assign idle = (st_q == ST_IDLE);

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    // Sticky error clears come first so a same-cycle set still wins
    always_comb begin
        st_d = st_q;
        chain_d = chain_q;
        src_d = src_q;
        dst_d = dst_q;
        len_d = len_q;
        cur_d = cur_q;
        tail_d = tail_q;
        err_d = err_q;
        derr_d = derr_q;
        mov_d = mov_q;
        cmd_d = cmd_q;
        rdata_d = rdata_q;
        go_rd = 1'b0;
        go_wr = 1'b0;
        f_base = {cur_q, 6'h00};

        // Register writes
        if (hit(REG_WE, REG_ADDR, OFS_CTRL)) begin
            chain_d = REG_WDATA[CTL_CHAIN_BIT];
        end
        if (hit(REG_WE, REG_ADDR, OFS_STAT)) begin
            // Write one to clear
            err_d = err_q & ~REG_WDATA[STA_ERR_LSB +: 3];
        end
        if (hit(REG_WE, REG_ADDR, OFS_CUR) && idle) begin
            // Pointer writes land only while idle; busy writes are dropped
            cur_d = REG_WDATA[31:PTR_LSB];
        end
        if (wr_tail) begin
            // While busy this only moves the pause point
            tail_d = REG_WDATA[31:PTR_LSB];
        end
        if (hit(REG_WE, REG_ADDR, OFS_SRC)) begin
            src_d = REG_WDATA;
        end
        if (hit(REG_WE, REG_ADDR, OFS_DST)) begin
            dst_d = REG_WDATA; // see [RULE_01]
        end
        if (wr_len) begin
            len_d = REG_WDATA[LEN_W-1:0]; // see [RULE_05], [RULE_08]
        end

        // Offer ends on the mover taking it
        if (mov_q && MOV_READY) begin
            mov_d = 1'b0;
        end

        unique case (st_q)
            ST_IDLE: begin
                if (wr_len && !chain_q) begin
                    if (bad_len(REG_WDATA[LEN_W-1:0], SIMPLE_MAX_LEN)) begin
                        err_d[ERR_INT] = 1'b1; // see [RULE_07]
                    end else begin
                        // Launch from the stored start words, see [RULE_06], [RULE_01]
                        cmd_d = '{src_q, dst_q, REG_WDATA[LEN_W-1:0]};
                        mov_d = 1'b1;
                        st_d = ST_SMOVE;
                    end
                end else if (wr_tail && chain_q) begin
                    // Fetch starts at the current pointer, see [RULE_18], [RULE_10]
                    go_rd = 1'b1;
                    derr_d = 3'h0;
                    st_d = ST_FETCH;
                end
            end
            ST_SMOVE: begin
                if (MOV_DONE) begin
                    err_d[ERR_SLV] = err_d[ERR_SLV] | MOV_ERR[MERR_SLV];
                    err_d[ERR_DEC] = err_d[ERR_DEC] | MOV_ERR[MERR_DEC];
                    st_d = ST_IDLE;
                end
            end
            ST_FETCH: begin
                if (f_done) begin
                    // Oversized or empty descriptor is refused, see [RULE_12], [RULE_11]
                    if (bad_len(f_desc.ctl[LEN_W-1:0], DESC_MAX_LEN)) begin
                        derr_d[ERR_INT] = 1'b1;
                        go_wr = 1'b1;
                        st_d = ST_WBACK;
                    end else begin
                        cmd_d = '{f_desc.rd, f_desc.wr, f_desc.ctl[LEN_W-1:0]};
                        mov_d = 1'b1;
                        st_d = ST_DMOVE;
                    end
                end
            end
            ST_DMOVE: begin
                if (MOV_DONE) begin
                    derr_d[ERR_SLV] = MOV_ERR[MERR_SLV];
                    derr_d[ERR_DEC] = MOV_ERR[MERR_DEC];
                    go_wr = 1'b1;
                    st_d = ST_WBACK;
                end
            end
            ST_WBACK: begin
                if (f_done) begin
                    err_d = err_d | derr_q;
                    if (|derr_q) begin
                        // Halt here; pointer keeps the failing descriptor, see [RULE_19]
                        st_d = ST_IDLE;
                    end else if (cur_q == tail_q) begin
                        // Pause point reached
                        st_d = ST_IDLE;
                    end else begin
                        // Walk on through the link, see [RULE_13], [RULE_16]
                        cur_d = f_desc.link[31:PTR_LSB];
                        f_base = {f_desc.link[31:PTR_LSB], 6'h00};
                        go_rd = 1'b1;
                        derr_d = 3'h0;
                        st_d = ST_FETCH;
                    end
                end
            end
        endcase

        // Read data, unmapped offsets read zero
        if (REG_RE) begin
            unique case (REG_ADDR)
                OFS_CTRL: rdata_d = {31'h0, chain_q};
                OFS_STAT: rdata_d = {25'h0, err_q, 2'h0, idle, 1'h0};
                OFS_CUR: rdata_d = {cur_q, 6'h00};
                OFS_TAIL: rdata_d = {tail_q, 6'h00};
                OFS_SRC: rdata_d = src_q;
                OFS_DST: rdata_d = dst_q;
                OFS_LEN: rdata_d = {9'h000, len_q}; // see [RULE_08]
                default: rdata_d = RST_WORD;
            endcase
        end
    end

    // Status word for the descriptor just finished, see [RULE_15]
    always_comb begin
        wb_word = RST_WORD;
        wb_word[DS_ERR_LSB +: 3] = derr_d;
        wb_word[DS_DONE_BIT] = ~|derr_d;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            st_q <= ST_IDLE;
            chain_q <= 1'b0;
            src_q <= RST_WORD;
            dst_q <= RST_WORD;
            len_q <= 23'h0;
            cur_q <= 26'h0;
            tail_q <= 26'h0;
            err_q <= 3'h0;
            derr_q <= 3'h0;
            mov_q <= 1'b0;
            cmd_q <= '0;
            rdata_q <= RST_WORD;
        end else begin
            st_q <= st_d;
            chain_q <= chain_d;
            src_q <= src_d;
            dst_q <= dst_d;
            len_q <= len_d;
            cur_q <= cur_d;
            tail_q <= tail_d;
            err_q <= err_d;
            derr_q <= derr_d;
            mov_q <= mov_d;
            cmd_q <= cmd_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // Descriptor memory sequencer
    // ----------------------------------------
    mcdma_fetch u_fetch (
        .mclk(MCLK),
        .srst(SRST),
        .go_rd(go_rd),
        .go_wr(go_wr),
        .base(f_base),
        .wdata(wb_word),
        .done(f_done),
        .desc(f_desc),
        .mem_req(MEM_REQ),
        .mem_we(MEM_WE),
        .mem_addr(MEM_ADDR),
        .mem_wdata(MEM_WDATA),
        .mem_ack(MEM_ACK),
        .mem_rdata(MEM_RDATA)
    );

    assign REG_RDATA = rdata_q;
    assign MOV_VALID = mov_q;
    assign MOV_CMD = cmd_q;
    assign ENGINE_IDLE = idle;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_len_high_zero: assert property ( // see [RULE_08]
        @(posedge MCLK) disable iff (SRST)
        REG_RE && REG_ADDR == OFS_LEN |=> REG_RDATA[31:23] == 9'h000)
    else $error("length upper bits not zero");

    chk_zero_no_copy: assert property ( // see [RULE_07]
        @(posedge MCLK) disable iff (SRST)
        idle && !chain_q && wr_len && REG_WDATA[22:0] == 23'h0
        |=> !MOV_VALID && err_q[ERR_INT] && idle)
    else $error("zero length not refused");

    chk_len_launch: assert property ( // see [RULE_06]
        @(posedge MCLK) disable iff (SRST)
        idle && !chain_q && wr_len && REG_WDATA[22:0] != 23'h0
        && REG_WDATA[22:0] <= SIMPLE_MAX_LEN
        |=> MOV_VALID && MOV_CMD.len == $past(REG_WDATA[22:0]))
    else $error("length write did not launch copy");

    chk_dst_used: assert property ( // see [RULE_01]
        @(posedge MCLK) disable iff (SRST)
        $rose(MOV_VALID) && st_q == ST_SMOVE |-> MOV_CMD.dst == dst_q)
    else $error("simple copy write start wrong");

    chk_chain_gate: assert property ( // see [RULE_10]
        @(posedge MCLK) disable iff (SRST)
        idle && !chain_q |=> st_q != ST_FETCH && st_q != ST_DMOVE)
    else $error("descriptor work outside chained mode");

    chk_tail_fetch: assert property ( // see [RULE_18]
        @(posedge MCLK) disable iff (SRST)
        idle && chain_q && wr_tail && !MEM_REQ
        |=> MEM_REQ && !MEM_WE && MEM_ADDR == {$past(cur_q), 6'h00})
    else $error("tail write did not start fetch");

    chk_desc_limit: assert property ( // see [RULE_12]
        @(posedge MCLK) disable iff (SRST)
        st_q == ST_FETCH && f_done && f_desc.ctl[22:0] > DESC_MAX_LEN
        |=> st_q == ST_WBACK && !MOV_VALID)
    else $error("oversized descriptor executed");

    chk_link_follow: assert property ( // see [RULE_13]
        @(posedge MCLK) disable iff (SRST)
        st_q == ST_WBACK && f_done && derr_q == 3'h0 && cur_q != tail_q
        |=> st_q == ST_FETCH && cur_q == $past(f_desc.link[31:6]))
    else $error("chain link not followed");

    chk_error_halt: assert property ( // see [RULE_19]
        @(posedge MCLK) disable iff (SRST)
        st_q == ST_WBACK && f_done && derr_q != 3'h0
        |=> ENGINE_IDLE && $stable(cur_q) ##1 ENGINE_IDLE)
    else $error("engine did not halt on error");

endmodule // mcdma_setup

// ### verif/mcdma_far.sv
// Far-side model: data mover and descriptor memory
`timescale 1ns/1ns
module mcdma_far
    import mcdma_pkg::*;
(
    // Clock, pace and error injection
    input wire logic mclk,
    input wire logic slow,
    input wire logic [1:0] err_set,
    // Mover side
    input wire logic mov_valid,
    output logic mov_ready,
    input wire mcdma_cmd_t mov_cmd,
    output logic mov_done,
    output logic [1:0] mov_err,
    // Memory side
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [0:63]; // Descriptors, eight words each
    mcdma_cmd_t last; // Last command taken
    int ncmd = 0;
    int cnt = 0;
    logic ph = 1'b0;
    initial begin
        mov_ready = 1'b0;
        mov_done = 1'b0;
        mov_err = 2'b00;
        mem_ack = 1'b0;
        mem_rdata = 32'h0;
    end
    // ----------------------------------------
    // One pulse per taken command, done later
    // ----------------------------------------
    always @(posedge mclk) begin
        mov_ready <= 1'b0;
        mov_done <= 1'b0;
        mov_err <= ~err_set; // Error lanes mean nothing outside done
        if (mov_valid && !mov_ready && cnt == 0) begin
            mov_ready <= 1'b1;
            last <= mov_cmd;
            ncmd <= ncmd + 1;
            cnt <= slow ? 9 : 2;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            mov_done <= 1'b1;
            mov_err <= err_set;
        end
    end
    // ----------------------------------------
    // Memory: data only valid with the ack
    // ----------------------------------------
    always @(posedge mclk) begin
        ph <= ~ph;
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata; // Stale data is scrambled
        if (mem_req && !mem_ack && (!slow || ph)) begin
            mem_ack <= 1'b1;
            if (mem_we) begin
                mem[mem_addr[7:2]] <= mem_wdata; // Status word
            end else begin
                mem_rdata <= mem[mem_addr[7:2]];
            end
        end
    end
endmodule // mcdma_far

// ### verif/tb_memcopy_dma_setup.sv
// Self-checking testbench of the copy engine setup block
`timescale 1ns/1ns
module tb_memcopy_dma_setup
    import mcdma_pkg::*;
;
    logic MCLK = 1'b0, SRST = 1'b1, REG_WE = 1'b0, REG_RE = 1'b0, slow = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, v;
    logic MOV_VALID, MOV_READY, MOV_DONE, MEM_REQ, MEM_WE, MEM_ACK, ENGINE_IDLE;
    logic [1:0] MOV_ERR, err_set = 2'b00;
    mcdma_cmd_t MOV_CMD;
    int n_fail = 0, num_checks = 0, n0;
    always #5 MCLK = ~MCLK;
    mcdma_setup u_dut (.MCLK(MCLK), .SRST(SRST), .REG_WE(REG_WE), .REG_RE(REG_RE),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .MOV_VALID(MOV_VALID), .MOV_READY(MOV_READY), .MOV_CMD(MOV_CMD), .MOV_DONE(MOV_DONE),
        .MOV_ERR(MOV_ERR), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
        .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
        .ENGINE_IDLE(ENGINE_IDLE));
    mcdma_far u_far (.mclk(MCLK), .slow(slow), .err_set(err_set), .mov_valid(MOV_VALID),
        .mov_ready(MOV_READY), .mov_cmd(MOV_CMD), .mov_done(MOV_DONE), .mov_err(MOV_ERR),
        .mem_req(MEM_REQ), .mem_we(MEM_WE), .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA),
        .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        REG_WE <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge MCLK);
        REG_WE <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge MCLK);
        REG_RE <= 1'b1;
        REG_ADDR <= a;
        @(posedge MCLK);
        REG_RE <= 1'b0;
        #1 check(name, REG_RDATA, exp);
    endtask
    // Bounded wait for the engine to go idle again
    task automatic wait_idle();
        // Let the launching edge settle first, or the old idle state is seen
        @(posedge MCLK);
        #1;
        for (int i = 0; i < 400 && !(ENGINE_IDLE === 1'b1); i++) begin
            @(posedge MCLK);
            #1;
        end
        check("idle", {31'h0, ENGINE_IDLE}, 32'h1);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Simple copy into host memory: aperture plus low 19 bits of 0x12345678
    task automatic t_simple();
        n0 = u_far.ncmd;
        wr(OFS_SRC, 32'h0000_1000);
        // Host side maps the translation window before this
        wr(OFS_DST, 32'h0008_0000 + 32'h0004_5678);
        rd(OFS_DST, 32'h000c_5678, "dst");
        rd(8'h3c, 32'h0, "unmapped");
        wr(OFS_LEN, 32'hff80_0010); // Idle before launch
        wait_idle();
        check("ncmd", u_far.ncmd - n0, 1);
        check("src", u_far.last.src, 32'h0000_1000);
        check("dst", u_far.last.dst, 32'h000c_5678);
        check("len", {9'h0, u_far.last.len}, 32'h10);
        rd(OFS_LEN, 32'h0000_0010, "len rd");
    endtask
    // Zero length refused; longest length taken with a slave error back
    task automatic t_lengths();
        n0 = u_far.ncmd;
        wr(OFS_LEN, 32'h0);
        repeat (3) @(posedge MCLK);
        check("ncmd0", u_far.ncmd - n0, 0);
        rd(OFS_STAT, 32'h12, "stat0");
        wr(OFS_STAT, 32'h70);
        slow <= 1'b1;
        err_set <= 2'b01;
        wr(OFS_LEN, 32'h007f_fffe);
        wait_idle();
        check("lenmax", {9'h0, u_far.last.len}, 32'h007f_fffe);
        rd(OFS_STAT, 32'h22, "stat slv");
        wr(OFS_STAT, 32'h70);
        slow <= 1'b0;
        err_set <= 2'b00;
    endtask
    // Two linked descriptors; link carries junk in its low bits
    task automatic t_chain();
        u_far.mem[16] = 32'h0000_00bf; // Next at 0x80
        u_far.mem[18] = 32'h2000;
        u_far.mem[20] = 32'h3000;
        u_far.mem[22] = 32'h0007_ffff; // Largest one
        u_far.mem[32] = 32'h0;
        u_far.mem[34] = 32'h4000;
        u_far.mem[36] = 32'h5000;
        u_far.mem[38] = 32'h8;
        n0 = u_far.ncmd;
        wr(OFS_CTRL, 32'h1);
        wr(OFS_LEN, 32'h5);
        repeat (3) @(posedge MCLK);
        check("nolaunch", u_far.ncmd - n0, 0);
        wr(OFS_CUR, 32'h40); // Written while idle
        wr(OFS_TAIL, 32'h80);
        wait_idle();
        check("ncmd2", u_far.ncmd - n0, 2);
        check("rd2", u_far.last.src, 32'h4000);
        check("len2", {9'h0, u_far.last.len}, 32'h8);
        check("st1", u_far.mem[23], 32'h8000_0000);
        check("st2", u_far.mem[39], 32'h8000_0000);
        rd(OFS_CUR, 32'h80, "cur");
    endtask
    // Zero-length, then oversized descriptor: each halts at that descriptor
    task automatic t_halt();
        u_far.mem[48] = 32'h0;
        u_far.mem[54] = 32'h0;
        n0 = u_far.ncmd;
        wr(OFS_CUR, 32'hc0);
        wr(OFS_TAIL, 32'hc0);
        wait_idle();
        check("ncmd3", u_far.ncmd - n0, 0);
        check("st3", u_far.mem[55], 32'h1000_0000);
        rd(OFS_CUR, 32'hc0, "cur halt");
        rd(OFS_STAT, 32'h12, "stat halt");
        wr(OFS_STAT, 32'h70);
        u_far.mem[54] = 32'h0008_0000; // One past the largest
        u_far.mem[55] = 32'h0;
        wr(OFS_TAIL, 32'hc0);
        wait_idle();
        check("ncmd4", u_far.ncmd - n0, 0);
        check("st4", u_far.mem[55], 32'h1000_0000);
    endtask
    // ----------------------------------------
    // Verdict and run control
    // ----------------------------------------
    task automatic results();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        results();
    end
    initial begin
        repeat (4) @(posedge MCLK);
        SRST <= 1'b0;
        rd(OFS_LEN, 32'h0, "len rst");
        t_simple();
        t_lengths();
        t_chain();
        t_halt();
        results();
    end
endmodule // tb_memcopy_dma_setup
